// >>> shared/rcb_pkg.sv
// Shared constants and carrier types for the radio control register bank.
package rcb_pkg;

	// APB geometry: byte address is four times the register index
	localparam int APB_AW = 16;
	localparam int IDX_W = 14;
	localparam int REG_COUNT = 21;

	// Register indices, byte address = index * 4
	localparam logic [IDX_W-1:0] IDX_RESET_CTRL = 14'h1000;
	localparam logic [IDX_W-1:0] IDX_MODE_STROBE = 14'h1001;
	localparam logic [IDX_W-1:0] IDX_MODE_TWO = 14'h1002;
	localparam logic [IDX_W-1:0] IDX_MODE_THREE = 14'h1003;
	localparam logic [IDX_W-1:0] IDX_VCO_CAL = 14'h1004;
	localparam logic [IDX_W-1:0] IDX_BANK_MAN = 14'h1005;
	localparam logic [IDX_W-1:0] IDX_FIFO_END = 14'h1006;
	localparam logic [IDX_W-1:0] IDX_FIFO_MARGIN = 14'h1007;
	localparam logic [IDX_W-1:0] IDX_RC_CTRL = 14'h1008;
	localparam logic [IDX_W-1:0] IDX_RC_TMR_HI = 14'h1009;
	localparam logic [IDX_W-1:0] IDX_RC_TMR_LO = 14'h100a;
	localparam logic [IDX_W-1:0] IDX_RC_TGT_HI = 14'h100b;
	localparam logic [IDX_W-1:0] IDX_RC_TGT_LO = 14'h100c;
	localparam logic [IDX_W-1:0] IDX_CLK_DIV = 14'h100d;
	localparam logic [IDX_W-1:0] IDX_RATE_DIV = 14'h100e;
	localparam logic [IDX_W-1:0] IDX_SYNTH_ONE = 14'h100f;
	localparam logic [IDX_W-1:0] IDX_LO_INT = 14'h1010;
	localparam logic [IDX_W-1:0] IDX_LO_FRAC_HI = 14'h1011;
	localparam logic [IDX_W-1:0] IDX_LO_FRAC_LO = 14'h1012;
	localparam logic [IDX_W-1:0] IDX_FC_HI = 14'h1013;
	localparam logic [IDX_W-1:0] IDX_FC_LO = 14'h1014;

	// Reset value of every stored byte
	localparam logic [7:0] REG_RESET_VAL = 8'h00;

	// Single-bit field positions
	localparam int B_RST_BB = 7;
	localparam int B_RST_TXP = 6;
	localparam int B_RST_RXP = 5;
	localparam int B_RST_ADC = 4;
	localparam int B_RST_FIFO = 3;
	localparam int B_RST_FILT = 2;
	localparam int B_FEC_FLAG = 6;
	localparam int B_CRC_FLAG = 5;
	localparam int B_MODE_STROBE_VALID = 7;
	localparam int B_DATA_PATH = 5;
	localparam int B_WOR_EN = 4;
	localparam int B_ADC_MEAS = 0;
	localparam int B_SWAP = 7;
	localparam int B_VCO_CAL = 2;
	localparam int B_FILT_CAL = 1;
	localparam int B_RSSI_CAL = 0;
	localparam int B_CRC_FILT = 7;
	localparam int B_VCO_SRC = 0;
	localparam int B_FILT_SRC = 4;
	localparam int B_RC_SINGLE = 2;
	localparam int B_RC_HAND = 1;
	localparam int B_RC_EN = 0;
	localparam int B_SLOW_OSC = 7;
	localparam int B_GEN_MUL = 0;
	localparam int B_LO_INT_HI = 7;
	localparam int B_CRC_INV = 6;
	localparam int B_AFC = 7;

	// Derived figures
	localparam logic [5:0] GEN_MUL_LOW_SEL = 6'h30;
	localparam logic [5:0] GEN_MUL_HIGH_SEL = 6'h20;
	localparam logic [2:0] RATE_SHIFT_NORM = 3'h7;
	localparam logic [2:0] RATE_SHIFT_DEMOD = 3'h6;
	localparam logic [6:0] MARGIN_STEP = 7'h04;
	localparam logic [6:0] FIFO_SPAN = 7'h40;
	localparam logic [4:0] CAL_DIV_BASE = 5'h02;

	// Operating modes, Gray coded along sleep-idle-standby-pll-rx-tx
	typedef enum logic [2:0] {
		RCB_SLEEP = 3'h0,
		RCB_IDLE = 3'h1,
		RCB_STANDBY = 3'h3,
		RCB_PLL = 3'h2,
		RCB_RX = 3'h6,
		RCB_TX = 3'h7
	} rcb_mode_e;

	typedef struct packed {
		logic power;
		logic chip_enable;
		logic crystal;
		logic synth;
		logic direction;
		logic active;
	} rcb_chip_status_s;

	typedef struct packed {
		logic baseband;
		logic tx_pointer;
		logic rx_pointer;
		logic wide_adc;
		logic rx_buffer;
		logic filter_cal;
	} rcb_soft_reset_s;

	typedef struct packed {
		logic adc;
		logic vco;
		logic filter;
		logic rssi;
	} rcb_cal_s;

	typedef struct packed {
		logic [6:0] mode_flags;
		logic [4:0] vco_fcd;
		logic [2:0] vco_bank_auto;
		logic [1:0] vt_detect;
		logic vco_cal_fail;
		logic filter_cal_fail;
		logic [3:0] filter_bank_auto;
		logic [11:0] rc_cal_result;
		logic [9:0] rc_osc_count;
		logic battery_low;
		logic rc_cal_busy;
		logic [14:0] freq_offset;
	} rcb_core_status_s;

	typedef struct packed {
		logic data_path_select;
		logic wor_enable;
		logic buffer_swap;
		logic crc_filter_enable;
		logic crc_invert;
		logic [7:0] buffer_end_index;
		logic [5:0] tx_payload_start;
		logic [1:0] cal_sample_divider;
		logic cal_single_select;
		logic cal_hand_override;
		logic rc_cal_enable;
		logic [9:0] rc_timer_manual;
		logic [11:0] rc_cal_target;
		logic slow_osc_source;
		logic [4:0] gen_ref_divider;
		logic gen_multiplier_select;
		logic [2:0] sys_clock_divider;
		logic [6:0] rate_divider;
		logic [8:0] lo_integer_word;
		logic [15:0] lo_fraction_word;
		logic auto_freq_comp_select;
	} rcb_radio_cfg_s;

	typedef struct packed {
		logic [REG_COUNT-1:0][7:0] regs;
		rcb_mode_e mode;
		logic fec_flag;
		logic crc_flag;
		rcb_chip_status_s sync1;
		rcb_chip_status_s sync2;
		rcb_soft_reset_s soft_reset;
		logic [7:0] rdata;
		logic slverr;
	} rcb_state_s;

endpackage

// >>> src/rcb_bank.sv
// APB register bank controlling and observing the sub-GHz radio core.
`timescale 1ns/1ps

// Summary of operation
// - Write pulses six separate soft resets
// - Reset register reads live chip status bits
// - FEC failure latched, cleared by read
// - CRC failure latched, cleared by read
// - Strobe upper bits select operating mode
// - Data path bit picks direct or FIFO
// - Wake-on-radio enable bit gates function
// - ADC measure bit self-clears on completion
// - Swap bit exchanges TX and RX buffers
// - Calibration triggers self-clear on completion
// - CRC filter enable and CRC invert bits
// - VCO and filter banks auto or manual
// - Buffer length is end index plus one
// - Margin code gives TX/RX threshold pair
// - Six-bit TX payload start address
// - RC calibration divider, mode, software-cleared enable
// - Cal result readable, target and timer writable
// - Slow oscillator internal or external source
// - Generator reference divide, multiply 48 or 32
// - System clock is master over divider+1
// - Rate divisor over 128, or 64 option
// - LO integer and fraction words
// - Compensation manual, or reads measured offset
module rcb_bank (
	input wire logic pclk, // APB clock, 40 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high writes
	input wire logic [rcb_pkg::APB_AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready, always high
	output logic pslverr, // APB error on unmapped access
	input wire rcb_pkg::rcb_chip_status_s chip_status_in, // Core status pins
	input wire logic fec_fail_evt, // FEC failure pulse
	input wire logic crc_fail_evt, // CRC failure pulse
	input wire rcb_pkg::rcb_cal_s cal_done, // Completion pulses
	input wire logic demod_rate_option, // Halves rate prescaler
	input wire rcb_pkg::rcb_core_status_s core_status, // Core readback
	output rcb_pkg::rcb_soft_reset_s soft_reset, // Reset pulses
	output rcb_pkg::rcb_mode_e op_mode, // Current operating mode
	output rcb_pkg::rcb_cal_s cal_trigger, // Trigger levels
	output rcb_pkg::rcb_radio_cfg_s radio_cfg, // Stored settings
	output logic [8:0] fifo_length, // Buffer length in bytes
	output logic [6:0] tx_margin, // TX threshold in bytes
	output logic [6:0] rx_margin, // RX threshold in bytes
	output logic [4:0] cal_sample_div, // RC cal clock divide ratio
	output logic [5:0] gen_ref_divisor, // Generator reference divide
	output logic [5:0] gen_multiplier, // Generator multiply factor
	output logic [18:0] rate_clock_divisor, // Master clock per bit
	output logic [2:0] vco_bank_sel, // VCO bank in use
	output logic [3:0] filter_bank_sel, // Filter bank in use
	output logic [14:0] freq_comp_value // Compensation word in use
);
	import rcb_pkg::*;

	rcb_state_s s_q; // Whole block state
	rcb_state_s s_d; // Next state
	logic [IDX_W-1:0] idx; // Word index from the address
	logic [IDX_W-1:0] rel; // Index relative to the bank base
	logic [4:0] ridx; // Slot in the byte array
	logic hit; // Address lands on a register
	logic setup; // APB setup phase
	logic wr; // Write taking effect this edge
	logic rd_status; // Read of the reset/status register
	logic [7:0] rval; // Read value for the addressed register
	logic [7:0] wb; // Written byte
	logic [14:0] fc_manual; // Software compensation word
	logic [3:0] sys_div; // System clock divide factor
	logic [7:0] rate_div; // Rate divide factor
	logic [11:0] div_prod; // Product of both dividers

	// Address decode; misaligned or out-of-range words are unmapped
	always_comb begin
		idx = paddr[APB_AW-1:2];
		rel = idx - IDX_RESET_CTRL;
		ridx = rel[4:0];
		hit = (paddr[1:0] == 2'h0) && (idx >= IDX_RESET_CTRL) &&
			(idx <= IDX_FC_LO);
	end

	assign setup = psel & ~penable;
	// Zero wait states, so the access edge is the commit edge
	assign wr = psel & penable & pwrite & pstrb[0] & hit;
	assign rd_status = psel & penable & ~pwrite & (idx == IDX_RESET_CTRL) &
		(paddr[1:0] == 2'h0);
	assign wb = pwdata[7:0];
	assign fc_manual = {s_q.regs[5'h13][6:0], s_q.regs[5'h14]};

	// Read value, captured in the setup phase
	always_comb begin
		case (idx)
			IDX_RESET_CTRL: begin
				// Live status and the two latched flags
				rval = {s_q.sync2.power, s_q.fec_flag, s_q.crc_flag,
					s_q.sync2.chip_enable, s_q.sync2.crystal,
					s_q.sync2.synth, s_q.sync2.direction,
					s_q.sync2.active};
			end
			IDX_MODE_STROBE: begin
				// Strobe is write-only; reads show core flags
				rval = {core_status.mode_flags, 1'b0};
			end
			IDX_VCO_CAL: begin
				rval = {core_status.vco_fcd, core_status.vco_bank_auto};
			end
			IDX_BANK_MAN: begin
				rval = {core_status.vt_detect, core_status.vco_cal_fail,
					core_status.filter_cal_fail,
					core_status.filter_bank_auto};
			end
			IDX_FIFO_END, IDX_FIFO_MARGIN, IDX_RC_TGT_HI,
			IDX_RC_TGT_LO: begin
				// Write-only settings read as zero
				rval = 8'h00;
			end
			IDX_RC_CTRL: begin
				rval = {core_status.rc_cal_result[11:8],
					core_status.battery_low,
					core_status.rc_osc_count[9:8],
					core_status.rc_cal_busy};
			end
			IDX_RC_TMR_HI: begin
				rval = core_status.rc_cal_result[7:0];
			end
			IDX_RC_TMR_LO: begin
				rval = core_status.rc_osc_count[7:0];
			end
			IDX_FC_HI: begin
				// Auto mode shows the measured offset
				rval = {s_q.regs[5'h13][B_AFC], freq_comp_value[14:8]};
			end
			IDX_FC_LO: begin
				rval = freq_comp_value[7:0];
			end
			default: begin
				// Plain read/write bytes and unmapped indices
				rval = hit ? s_q.regs[ridx] : 8'h00;
			end
		endcase
	end

	// Next-state logic for the whole bank
	always_comb begin
		s_d = s_q;
		// Status pins cross in through two flops
		s_d.sync1 = chip_status_in;
		s_d.sync2 = s_q.sync1;
		s_d.soft_reset = '0;

		// Hardware completion clears the triggers first, so a
		// software write in the same cycle wins
		if (cal_done.adc) begin
			s_d.regs[5'h02][B_ADC_MEAS] = 1'b0;
		end
		if (cal_done.vco) begin
			s_d.regs[5'h03][B_VCO_CAL] = 1'b0;
		end
		if (cal_done.filter) begin
			s_d.regs[5'h03][B_FILT_CAL] = 1'b0;
		end
		if (cal_done.rssi) begin
			s_d.regs[5'h03][B_RSSI_CAL] = 1'b0;
		end

		// Only the bits that were reported are cleared; an event
		// in the same edge sets the flag again
		s_d.fec_flag = (s_q.fec_flag &
			~(rd_status & s_q.rdata[B_FEC_FLAG])) | fec_fail_evt;
		s_d.crc_flag = (s_q.crc_flag &
			~(rd_status & s_q.rdata[B_CRC_FLAG])) | crc_fail_evt;

		if (wr) begin
			case (idx)
				IDX_RESET_CTRL: begin
					// Each written one gives a one-cycle pulse
					s_d.soft_reset.baseband = wb[B_RST_BB];
					s_d.soft_reset.tx_pointer = wb[B_RST_TXP];
					s_d.soft_reset.rx_pointer = wb[B_RST_RXP];
					s_d.soft_reset.wide_adc = wb[B_RST_ADC];
					s_d.soft_reset.rx_buffer = wb[B_RST_FIFO];
					s_d.soft_reset.filter_cal = wb[B_RST_FILT];
				end
				IDX_MODE_STROBE: begin
					if (wb[B_MODE_STROBE_VALID]) begin
						case (wb[6:3])
							4'h0: begin
								s_d.mode = RCB_SLEEP;
							end
							4'h2, 4'h3: begin
								s_d.mode = RCB_IDLE;
							end
							4'h4, 4'h5: begin
								s_d.mode = RCB_STANDBY;
							end
							4'h6, 4'h7: begin
								s_d.mode = RCB_PLL;
							end
							4'h8, 4'h9: begin
								s_d.mode = RCB_RX;
							end
							4'ha, 4'hb: begin
								s_d.mode = RCB_TX;
							end
							default: begin
								// Unknown pattern: mode kept
								s_d.mode = s_q.mode;
							end
						endcase
					end
				end
				default: begin
					// Stored bytes, including trigger bits
					s_d.regs[ridx] = wb;
				end
			endcase
		end

		// Read data and error are held from setup to access
		if (setup) begin
			// Unmapped or misaligned reads return zero, not a neighbour
			s_d.rdata = (pwrite || !hit) ? 8'h00 : rval;
			s_d.slverr = ~hit;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.regs <= {REG_COUNT{REG_RESET_VAL}};
			s_q.mode <= RCB_SLEEP;
			s_q.fec_flag <= 1'b0;
			s_q.crc_flag <= 1'b0;
			s_q.sync1 <= '0;
			s_q.sync2 <= '0;
			s_q.soft_reset <= '0;
			s_q.rdata <= 8'h00;
			s_q.slverr <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// APB answers with no wait states
	assign pready = 1'b1;
	assign prdata = {24'h000000, s_q.rdata};
	assign pslverr = s_q.slverr & psel & penable;

	assign soft_reset = s_q.soft_reset;
	assign op_mode = s_q.mode;

	// Trigger levels stay up until the core reports completion
	assign cal_trigger.adc = s_q.regs[5'h02][B_ADC_MEAS];
	assign cal_trigger.vco = s_q.regs[5'h03][B_VCO_CAL];
	assign cal_trigger.filter = s_q.regs[5'h03][B_FILT_CAL];
	assign cal_trigger.rssi = s_q.regs[5'h03][B_RSSI_CAL];

	// Settings straight from the stored bytes
	always_comb begin
		radio_cfg.data_path_select = s_q.regs[5'h02][B_DATA_PATH];
		radio_cfg.wor_enable = s_q.regs[5'h02][B_WOR_EN];
		radio_cfg.buffer_swap = s_q.regs[5'h03][B_SWAP];
		radio_cfg.crc_filter_enable = s_q.regs[5'h04][B_CRC_FILT];
		radio_cfg.crc_invert = s_q.regs[5'h0f][B_CRC_INV];
		radio_cfg.buffer_end_index = s_q.regs[5'h06];
		radio_cfg.tx_payload_start = s_q.regs[5'h07][5:0];
		radio_cfg.cal_sample_divider = s_q.regs[5'h08][4:3];
		radio_cfg.cal_single_select = s_q.regs[5'h08][B_RC_SINGLE];
		radio_cfg.cal_hand_override = s_q.regs[5'h08][B_RC_HAND];
		// Enable is never cleared by hardware; software drops it
		radio_cfg.rc_cal_enable = s_q.regs[5'h08][B_RC_EN];
		radio_cfg.rc_timer_manual = {s_q.regs[5'h09][1:0],
			s_q.regs[5'h0a]};
		radio_cfg.rc_cal_target = {s_q.regs[5'h0b][3:0],
			s_q.regs[5'h0c]};
		radio_cfg.slow_osc_source = s_q.regs[5'h0b][B_SLOW_OSC];
		radio_cfg.gen_ref_divider = s_q.regs[5'h0d][7:3];
		radio_cfg.gen_multiplier_select = s_q.regs[5'h0e][B_GEN_MUL];
		radio_cfg.sys_clock_divider = s_q.regs[5'h0d][2:0];
		radio_cfg.rate_divider = s_q.regs[5'h0e][7:1];
		radio_cfg.lo_integer_word = {s_q.regs[5'h0f][B_LO_INT_HI],
			s_q.regs[5'h10]};
		radio_cfg.lo_fraction_word = {s_q.regs[5'h11],
			s_q.regs[5'h12]};
		radio_cfg.auto_freq_comp_select = s_q.regs[5'h13][B_AFC];
	end

	// Buffer sizing; a full 8-bit index gives a 256-byte buffer
	assign fifo_length = {1'b0, s_q.regs[5'h06]} + 9'h001;
	assign tx_margin = 7'(({5'h00, s_q.regs[5'h07][7:6]} + 7'h01) *
		MARGIN_STEP);
	assign rx_margin = FIFO_SPAN - tx_margin;

	// RC calibration sample clock divide: 2, 4, 8 or 16
	assign cal_sample_div = CAL_DIV_BASE << s_q.regs[5'h08][4:3];

	// Clock generator reference and multiplier
	assign gen_ref_divisor = {1'b0, s_q.regs[5'h0d][7:3]} + 6'h01;
	assign gen_multiplier = s_q.regs[5'h0e][B_GEN_MUL] ?
		GEN_MUL_HIGH_SEL : GEN_MUL_LOW_SEL;

	// Master clock cycles per data bit; the master clock itself is
	// chosen outside this bank, so only the divide chain lives here
	assign sys_div = {1'b0, s_q.regs[5'h0d][2:0]} + 4'h1;
	assign rate_div = {1'b0, s_q.regs[5'h0e][7:1]} + 8'h01;
	assign div_prod = 12'(sys_div) * 12'(rate_div);
	assign rate_clock_divisor = 19'(div_prod) <<
		(demod_rate_option ? RATE_SHIFT_DEMOD : RATE_SHIFT_NORM);

	// Band selection, auto result unless manual select is set
	assign vco_bank_sel = s_q.regs[5'h04][B_VCO_SRC] ?
		s_q.regs[5'h05][7:5] : core_status.vco_bank_auto;
	assign filter_bank_sel = s_q.regs[5'h05][B_FILT_SRC] ?
		s_q.regs[5'h05][3:0] : core_status.filter_bank_auto;

	// Compensation word: manual when auto is off
	assign freq_comp_value = s_q.regs[5'h13][B_AFC] ?
		core_status.freq_offset : fc_manual;

endmodule

// >>> tb/rcb_bank_monitor.sv
// Port-level assertions for the radio control register bank.
`timescale 1ns/1ps
module rcb_bank_monitor (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Access phase
	input wire logic pwrite, // Direction
	input wire logic [rcb_pkg::APB_AW-1:0] paddr, // Byte address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [3:0] pstrb, // Byte strobes
	input wire logic [31:0] prdata, // Read data
	input wire logic fec_fail_evt, // FEC fail pulse
	input wire logic crc_fail_evt, // CRC fail pulse
	input wire rcb_pkg::rcb_cal_s cal_done, // Done pulses
	input wire logic demod_rate_option, // Rate option
	input wire rcb_pkg::rcb_core_status_s core_status, // Core readback
	input wire rcb_pkg::rcb_soft_reset_s soft_reset, // Reset pulses
	input wire rcb_pkg::rcb_mode_e op_mode, // Operating mode
	input wire rcb_pkg::rcb_cal_s cal_trigger, // Trigger levels
	input wire rcb_pkg::rcb_radio_cfg_s radio_cfg, // Settings
	input wire logic [8:0] fifo_length, // Buffer length
	input wire logic [6:0] tx_margin, // TX threshold
	input wire logic [6:0] rx_margin, // RX threshold
	input wire logic [4:0] cal_sample_div, // RC cal divide
	input wire logic [5:0] gen_ref_divisor, // Generator divide
	input wire logic [5:0] gen_multiplier, // Generator multiply
	input wire logic [18:0] rate_clock_divisor, // Clocks per bit
	input wire logic [14:0] freq_comp_value // Compensation word
);
	import rcb_pkg::*;
	// Mode picked by strobe bits [6:4]
	localparam rcb_mode_e MODES [6] = '{RCB_SLEEP, RCB_IDLE, RCB_STANDBY,
		RCB_PLL, RCB_RX, RCB_TX};
	logic wr; // Committed write this edge
	logic rd_stat; // Status read setup, flags captured here
	logic mode_strobe_ok; // Strobe write with a listed pattern
	assign wr = psel && penable && pwrite && pstrb[0];
	assign rd_stat = psel && !penable && !pwrite && paddr == 16'h4000;
	assign mode_strobe_ok = wr && paddr == 16'h4004 && pwdata[7] &&
		pwdata[6:3] != 4'h1 && pwdata[6:5] != 2'b11;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_soft_pulse: assert property (
		wr && paddr == 16'h4000 |=> 6'(soft_reset) == $past(pwdata[7:2]))
		else $error("soft reset pulse wrong");
	a_soft_idle: assert property (
		!(wr && paddr == 16'h4000) |=> 6'(soft_reset) == 6'h0)
		else $error("soft reset without write");
	a_mode_hold: assert property (
		!mode_strobe_ok |=> $stable(op_mode))
		else $error("mode changed without valid strobe");
	a_mode_pick: assert property (
		mode_strobe_ok |=> op_mode == MODES[$past(pwdata[6:4])])
		else $error("strobe picked wrong mode");
	a_trig_clear: assert property (
		cal_done != 4'h0 && !wr |=>
		(4'(cal_trigger) & 4'($past(cal_done))) == 4'h0)
		else $error("trigger not cleared on completion");
	a_fec_seen: assert property (
		fec_fail_evt ##1 rd_stat |=> prdata[6])
		else $error("fec flag not latched");
	a_crc_seen: assert property (
		crc_fail_evt ##1 rd_stat |=> prdata[5])
		else $error("crc flag not latched");
	a_fifo_len: assert property (
		fifo_length == 9'(radio_cfg.buffer_end_index) + 9'h1)
		else $error("buffer length wrong");
	a_margin_pair: assert property (
		7'(tx_margin + rx_margin) == 7'h40 && tx_margin[1:0] == 2'b00 &&
		tx_margin != 7'h0 && tx_margin <= 7'h10)
		else $error("margin pair wrong");
	a_gen_clock: assert property (
		gen_ref_divisor == 6'(radio_cfg.gen_ref_divider) + 6'h1 &&
		gen_multiplier == (radio_cfg.gen_multiplier_select ? 6'h20 : 6'h30))
		else $error("generator figures wrong");
	a_rate_div: assert property (
		rate_clock_divisor == ((19'(radio_cfg.sys_clock_divider) + 19'h1) *
		(19'(radio_cfg.rate_divider) + 19'h1) << (demod_rate_option ? 6 : 7)))
		else $error("rate divisor wrong");
	a_sample_div: assert property (
		cal_sample_div == 5'(5'h2 << radio_cfg.cal_sample_divider))
		else $error("sample divider wrong");
	a_comp_auto: assert property (
		radio_cfg.auto_freq_comp_select |-> freq_comp_value ==
		core_status.freq_offset)
		else $error("compensation not measured value");
endmodule

bind rcb_bank rcb_bank_monitor i_monitor (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .fec_fail_evt, .crc_fail_evt,
	.cal_done, .demod_rate_option, .core_status, .soft_reset, .op_mode,
	.cal_trigger, .radio_cfg, .fifo_length, .tx_margin, .rx_margin,
	.cal_sample_div, .gen_ref_divisor, .gen_multiplier, .rate_clock_divisor,
	.freq_comp_value);

// >>> tb/rcb_bank_tb_top.sv
// Self-checking bench driving the register bank over APB.
`timescale 1ns/1ps
module rcb_bank_tb_top;
	import rcb_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // Bus
	logic [15:0] paddr; // Byte address
	logic [31:0] pwdata, prdata; // Data
	logic [3:0] pstrb; // Strobes
	logic fec_fail_evt, crc_fail_evt, demod_rate_option; // Core events
	rcb_chip_status_s chip_status_in; // Status pins
	rcb_cal_s cal_done, cal_trigger; // Calibration handshake
	rcb_core_status_s core_status; // Core readback
	rcb_soft_reset_s soft_reset; // Reset pulses
	rcb_mode_e op_mode; // Mode
	rcb_radio_cfg_s radio_cfg; // Settings
	logic [8:0] fifo_length; // Derived outputs
	logic [6:0] tx_margin, rx_margin;
	logic [4:0] cal_sample_div;
	logic [5:0] gen_ref_divisor, gen_multiplier;
	logic [18:0] rate_clock_divisor;
	logic [2:0] vco_bank_sel;
	logic [3:0] filter_bank_sel;
	logic [14:0] freq_comp_value;
	logic [31:0] rd; // Last read data
	logic err; // Last error response
	int n_errors, checked; // Tallies
	// Strobe bytes and the mode each leaves; 8'h88 and 8'he0 are not listed, 8'h50 lacks the valid bit
	logic [7:0] mode_strobe [9] = '{8'h97, 8'h80, 8'ha8, 8'hbf, 8'hc3, 8'hdc,
		8'h88, 8'he0, 8'h50};
	rcb_mode_e mexp [9] = '{RCB_IDLE, RCB_SLEEP, RCB_STANDBY, RCB_PLL,
		RCB_RX, RCB_TX, RCB_TX, RCB_TX, RCB_TX};
	// Plain and write-only bytes, all zero out of reset
	logic [15:0] zeros [12] = '{16'h4008, 16'h400c, 16'h4018, 16'h401c,
		16'h402c, 16'h4030, 16'h4034, 16'h4038, 16'h403c, 16'h4040,
		16'h4044, 16'h4048};

	rcb_bank i_dut (.*);

	// Free-running bus clock, 25 ns period
	always #12.5 pclk = ~pclk;

	// Compare and tally
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic finish_test();
		if (n_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One APB transfer; also ends any one-cycle core pulse
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [7:0] d, input logic [3:0] s);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		fec_fail_evt <= 1'b0;
		crc_fail_evt <= 1'b0;
		cal_done <= '0;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// Bounded wait for ready
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_errors++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 4'hf);
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00, 4'hf);
		check(rd, {24'h0, exp});
	endtask

	// Main sequence
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, fec_fail_evt, crc_fail_evt} = '0;
		demod_rate_option = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = '0;
		cal_done = '0;
		chip_status_in = '0;
		core_status = '0;
		core_status.vco_bank_auto = 3'h2;
		core_status.freq_offset = 15'h2bcd;
		core_status.rc_cal_result = 12'h5c3;
		n_errors = 0;
		checked = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		check(fifo_length, 9'd1);
		check({tx_margin, rx_margin}, {7'd4, 7'd60});
		check({gen_ref_divisor, gen_multiplier}, {6'd1, 6'd48});
		check(rate_clock_divisor, 19'd128);
		check(op_mode, RCB_SLEEP);
		foreach (zeros[i]) rd_chk(zeros[i], 8'h00);
		// Soft resets: one pulse per bit, gone a cycle later
		for (int i = 0; i < 6; i++) begin
			wr_reg(16'h4000, 8'h04 << i);
			check(soft_reset, 6'h01 << i);
			@(posedge pclk);
			#1;
			check(soft_reset, 6'h00);
		end
		// Live status, both direction levels
		@(posedge pclk);
		chip_status_in <= 6'b101011;
		repeat (3) @(posedge pclk);
		rd_chk(16'h4000, 8'h8b);
		chip_status_in <= 6'b010100;
		repeat (3) @(posedge pclk);
		rd_chk(16'h4000, 8'h14);
		// Latched flags, cleared by the read that returns them
		for (int j = 0; j < 2; j++) begin
			@(posedge pclk);
			if (j == 0) fec_fail_evt <= 1'b1;
			else crc_fail_evt <= 1'b1;
			rd_chk(16'h4000, 8'h14 | (8'h40 >> j));
			rd_chk(16'h4000, 8'h14);
		end
		// One strobe pattern per mode, then unlisted ones and one without the valid bit
		foreach (mode_strobe[i]) begin
			wr_reg(16'h4004, mode_strobe[i]);
			check(op_mode, mexp[i]);
		end
		// Data path and wake enable, masked write ignored
		wr_reg(16'h4008, 8'h30);
		xfer(1'b1, 16'h4008, 8'h00, 4'h0);
		rd_chk(16'h4008, 8'h30);
		check({radio_cfg.data_path_select, radio_cfg.wor_enable}, 2'b11);
		// Triggers set by software, cleared by completion
		for (int k = 0; k < 4; k++) begin
			wr_reg(k == 0 ? 16'h4008 : 16'h400c, k == 0 ? 8'h01 : 8'h08 >> k);
			check(cal_trigger, 4'h8 >> k);
			@(posedge pclk);
			cal_done <= 4'h8 >> k;
			rd_chk(k == 0 ? 16'h4008 : 16'h400c, 8'h00);
			check(cal_trigger, 4'h0);
		end
		wr_reg(16'h400c, 8'h80);
		check(radio_cfg.buffer_swap, 1'b1);
		// Buffer geometry
		wr_reg(16'h4018, 8'h3f);
		check(fifo_length, 9'd64);
		for (int c = 0; c < 4; c++) begin
			wr_reg(16'h401c, {c[1:0], 6'h15});
			check({tx_margin, rx_margin}, {7'(4 * c + 4), 7'(60 - 4 * c)});
		end
		check(radio_cfg.tx_payload_start, 6'h15);
		// RC calibration controls
		for (int c = 0; c < 4; c++) begin
			wr_reg(16'h4020, {3'h0, c[1:0], 3'b111});
			check(cal_sample_div, 5'h2 << c);
		end
		check({radio_cfg.cal_single_select, radio_cfg.cal_hand_override,
			radio_cfg.rc_cal_enable}, 3'b111);
		wr_reg(16'h4024, 8'h03);
		wr_reg(16'h4028, 8'h5a);
		wr_reg(16'h402c, 8'h8c);
		wr_reg(16'h4030, 8'hde);
		check({radio_cfg.rc_timer_manual, radio_cfg.rc_cal_target}, 22'h35acde);
		// Calibration result comes back from the core, not the writes
		rd_chk(16'h4024, 8'hc3);
		rd_chk(16'h4020, 8'h50);
		check(radio_cfg.slow_osc_source, 1'b1);
		// Clock dividers and rate
		wr_reg(16'h4034, {5'h03, 3'h2});
		wr_reg(16'h4038, {7'h04, 1'b1});
		check({gen_ref_divisor, gen_multiplier}, {6'd4, 6'd32});
		check(rate_clock_divisor, 19'd1920);
		@(posedge pclk);
		demod_rate_option <= 1'b1;
		#1;
		check(rate_clock_divisor, 19'd960);
		// LO words and CRC options
		wr_reg(16'h403c, 8'hc0);
		wr_reg(16'h4040, 8'h5a);
		wr_reg(16'h4044, 8'h12);
		wr_reg(16'h4048, 8'h34);
		check({radio_cfg.lo_integer_word, radio_cfg.lo_fraction_word}, 25'h15a1234);
		check(vco_bank_sel, 3'h2);
		wr_reg(16'h4010, 8'h81);
		wr_reg(16'h4014, 8'hba);
		check({radio_cfg.crc_filter_enable, radio_cfg.crc_invert}, 2'b11);
		check({vco_bank_sel, filter_bank_sel}, 7'h5a);
		// Compensation manual, then measured
		wr_reg(16'h404c, 8'h12);
		wr_reg(16'h4050, 8'h34);
		check(freq_comp_value, 15'h1234);
		wr_reg(16'h404c, 8'h80);
		check(freq_comp_value, 15'h2bcd);
		// Reads in auto mode show the measured offset
		rd_chk(16'h404c, 8'hab);
		rd_chk(16'h4050, 8'hcd);
		// Unmapped and misaligned accesses
		xfer(1'b0, 16'h4054, 8'h00, 4'hf);
		check({err, rd}, {1'b1, 32'h0});
		xfer(1'b1, 16'h4006, 8'hff, 4'hf);
		check(err, 1'b1);
		finish_test();
	end
endmodule
